/* File: pkg/sec_irq_pkg.sv */
package sec_irq_pkg;
  // ----------------------------------------------------------------
  // Register map (word index; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] SEC_IRQ_IDX = 8'h13;
  localparam logic [7:0] RX_ERR_IDX = 8'h15;
  localparam logic [7:0] PRIMARY_IRQ_IDX = 8'h12;
  localparam logic [15:0] SEC_IRQ_RESET = 16'h0000;
  localparam logic [15:0] RX_ERR_RESET = 16'h0000;
  localparam logic [15:0] PRIMARY_IRQ_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions of the secondary status and enable register
  // ----------------------------------------------------------------
  localparam int UNDER_VOLT_BIT = 15;
  localparam int OVER_VOLT_BIT = 14;
  localparam int SLEEP_BIT = 10;
  localparam int POL_BIT = 9;
  localparam int JABBER_BIT = 8;
  localparam int UNDER_VOLT_EN_BIT = 7;
  localparam int OVER_VOLT_EN_BIT = 6;
  localparam int SLEEP_EN_BIT = 2;
  localparam int POL_EN_BIT = 1;
  localparam int JABBER_EN_BIT = 0;
  localparam logic [15:0] SEC_EN_MASK = 16'h00FF;

  // Primary register: half-full flag and its enable
  localparam int HALF_FULL_BIT = 8;
  localparam int HALF_FULL_EN_BIT = 0;

  // ----------------------------------------------------------------
  // Counter limits
  // ----------------------------------------------------------------
  localparam logic [15:0] RX_ERR_MAX = 16'hFFFF;
  localparam logic [15:0] RX_ERR_HALF = 16'h7FFF;
endpackage : sec_irq_pkg

/* File: logic/phy_secondary_irq_and_rx_error_counter.sv */
`timescale 1ns/10ps
module phy_secondary_irq_and_rx_error_counter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic under_volt_i,
  input wire logic over_volt_i,
  input wire logic sleep_state_i,
  input wire logic link_slave_i,
  input wire logic pol_swap_i,
  input wire logic jabber_i,
  input wire logic carrier_valid_i,
  input wire logic rx_dv_i,
  input wire logic rx_symbol_err_i,
  input wire logic mac_loopback_i,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Decode results for the request on the bus this cycle
  logic req;
  logic sel_sec;
  logic sel_cnt;
  logic sel_pri;
  logic hit;
  logic rd_strobe;
  logic wr_lo;
  logic wr_sec;
  logic wr_pri;
  logic aligned;
  logic [7:0] word_idx;

  // Request is one new access per ack; ack high gaps the cycle after.
  // A master that holds stb through the ack gets a second access two
  // cycles later, never a double write in back-to-back cycles.
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign word_idx = wb_adr_i[9:2];
  assign aligned = (wb_adr_i[1:0] == 2'h0);
  assign wr_lo = req & wb_we_i & wb_sel_i[0];
  assign rd_strobe = req & ~wb_we_i;

  // Per-register write strobes; only byte lane 0 holds writable bits,
  // so lanes 1 to 3 are accepted and dropped
  assign wr_sec = wr_lo & sel_sec;
  assign wr_pri = wr_lo & sel_pri;

  // Address decoding; a misaligned byte address maps to nothing
  // and is answered with an error instead of an ack
  always_comb begin
    sel_sec = 1'b0;
    sel_cnt = 1'b0;
    sel_pri = 1'b0;
    hit = 1'b0;
    if (!aligned) begin
      hit = 1'b0;
    end else if (word_idx == sec_irq_pkg::SEC_IRQ_IDX) begin
      sel_sec = 1'b1;
      hit = 1'b1;
    end else if (word_idx == sec_irq_pkg::RX_ERR_IDX) begin
      sel_cnt = 1'b1;
      hit = 1'b1;
    end else if (word_idx == sec_irq_pkg::PRIMARY_IRQ_IDX) begin
      sel_pri = 1'b1;
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // Sleep level history and its change strobe
  logic sleep_prev_reg;
  logic sleep_seen_reg;
  logic sleep_change;

  // Sleep level of the previous cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_prev_reg <= 1'b0;
    end else begin
      sleep_prev_reg <= sleep_state_i;
    end
  end

  // Armed after the first sample: a pin that idles high out of reset
  // must not look like a change of sleep state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_seen_reg <= 1'b0;
    end else begin
      sleep_seen_reg <= 1'b1;
    end
  end

  // Either direction of change counts as one event
  assign sleep_change = sleep_seen_reg & (sleep_state_i != sleep_prev_reg);

  // ----------------------------------------------------------------
  // Status flags, cleared by reading their register; set wins
  // ----------------------------------------------------------------
  // Five secondary flags, under voltage in the top bit
  logic [4:0] flag_reg;
  logic [4:0] flag_next;
  logic [4:0] flag_set;
  logic half_full_reg;
  logic half_next;
  logic half_evt;
  logic clr_sec;

  // Event inputs in flag order; polarity counts only as link slave
  assign flag_set = {under_volt_i,
                     over_volt_i,
                     sleep_change,
                     link_slave_i & pol_swap_i,
                     jabber_i};

  // A read of the secondary register clears all five flags at once
  assign clr_sec = rd_strobe & sel_sec;

  // Flags latch without regard to enables. The clear is applied first
  // and the set after it, so an event in the reading cycle is kept and
  // shows in the next read instead of being lost.
  always_comb begin
    flag_next = flag_reg;
    if (clr_sec) begin
      flag_next = 5'h00;
    end
    flag_next = flag_next | flag_set;
  end

  // Flag storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= 5'h00;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ----------------------------------------------------------------
  // Enable bits
  // ----------------------------------------------------------------
  // Stored enable bits
  logic [7:0] en_reg;
  logic pri_en_reg;

  // Low byte holds all secondary enables, high byte is read-only.
  // Page, fifo and the reserved bit store and read back but gate
  // nothing here, since their sources live outside this block.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_reg <= sec_irq_pkg::SEC_IRQ_RESET[7:0];
    end else if (wr_sec) begin
      en_reg <= wb_dat_i[7:0];
    end
  end

  // Primary half-full enable; the other primary bits belong to
  // sources outside this block and read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pri_en_reg <= sec_irq_pkg::PRIMARY_IRQ_RESET[sec_irq_pkg::HALF_FULL_EN_BIT];
    end else if (wr_pri) begin
      pri_en_reg <= wb_dat_i[sec_irq_pkg::HALF_FULL_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Receive error counter
  // ----------------------------------------------------------------
  // Count, its next value and the strobes that move it
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic cnt_inc;
  logic clr_cnt;

  // Only symbol errors inside a received frame count, and none at all
  // while the MAC-side loopback is on
  assign cnt_inc = carrier_valid_i & rx_dv_i & rx_symbol_err_i & ~mac_loopback_i;
  assign clr_cnt = rd_strobe & sel_cnt;

  logic [15:0] cnt_base;
  logic cnt_at_max;

  // Value after a clearing read, before this cycle's error is added
  always_comb begin
    cnt_base = cnt_reg;
    if (clr_cnt) begin
      cnt_base = 16'h0000;
    end
  end

  // All ones holds; further errors are dropped rather than wrapping
  assign cnt_at_max = (cnt_base == sec_irq_pkg::RX_ERR_MAX);

  // Read clears; an error in the read cycle starts the new count at one
  always_comb begin
    cnt_next = cnt_base;
    if (cnt_inc & ~cnt_at_max) begin
      cnt_next = cnt_base + 16'h0001;
    end
  end

  // Count storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= sec_irq_pkg::RX_ERR_RESET;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Event when the count first moves above the half mark; a count that
  // sits at all ones does not raise it again
  assign half_evt = (cnt_next > sec_irq_pkg::RX_ERR_HALF) && (cnt_reg <= sec_irq_pkg::RX_ERR_HALF);

  // Half-full flag next value; the crossing wins over a clearing read
  always_comb begin
    half_next = half_full_reg;
    if (rd_strobe & sel_pri) begin
      half_next = 1'b0;
    end
    if (half_evt) begin
      half_next = 1'b1;
    end
  end

  // Half-full flag storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_full_reg <= 1'b0;
    end else begin
      half_full_reg <= half_next;
    end
  end

  // ----------------------------------------------------------------
  // Read data assembly
  // ----------------------------------------------------------------
  // Register views and the word handed to the bus
  logic [15:0] sec_view;
  logic [15:0] pri_view;
  logic [31:0] rd_data;

  // Secondary view: reserved status positions stay zero, enables
  // read back as written
  always_comb begin
    sec_view = 16'h0000;
    sec_view[sec_irq_pkg::UNDER_VOLT_BIT] = flag_reg[4];
    sec_view[sec_irq_pkg::OVER_VOLT_BIT] = flag_reg[3];
    sec_view[sec_irq_pkg::SLEEP_BIT] = flag_reg[2];
    sec_view[sec_irq_pkg::POL_BIT] = flag_reg[1];
    sec_view[sec_irq_pkg::JABBER_BIT] = flag_reg[0];
    sec_view[7:0] = en_reg & sec_irq_pkg::SEC_EN_MASK[7:0];
  end

  // Primary view: half-full flag and its enable, all else zero
  always_comb begin
    pri_view = 16'h0000;
    pri_view[sec_irq_pkg::HALF_FULL_BIT] = half_full_reg;
    pri_view[sec_irq_pkg::HALF_FULL_EN_BIT] = pri_en_reg;
  end

  // Word for the addressed register; the upper half is always zero
  always_comb begin
    rd_data = 32'h00000000;
    if (sel_sec) begin
      rd_data = {16'h0000, sec_view};
    end else if (sel_cnt) begin
      rd_data = {16'h0000, cnt_reg};
    end else if (sel_pri) begin
      rd_data = {16'h0000, pri_view};
    end
  end

  // ----------------------------------------------------------------
  // Bus answer: one cycle after the request, err for unmapped
  // ----------------------------------------------------------------
  // Acknowledge for a mapped register, one cycle wide
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & hit;
    end
  end

  // Error for an unmapped or misaligned address; nothing else moves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_err_o <= 1'b0;
    end else begin
      wb_err_o <= req & ~hit;
    end
  end

  // Read data is captured with the request and held until the next mapped
  // read, so a slow master still finds it after the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (rd_strobe & hit) begin
      wb_dat_o <= rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Combined interrupt output
  // ----------------------------------------------------------------
  logic [4:0] flag_en;
  logic [4:0] pend_next;
  logic half_pend_next;
  logic irq_next;

  // Enable bits of the five sources, in the order of the flag vector
  assign flag_en = {en_reg[sec_irq_pkg::UNDER_VOLT_EN_BIT],
                    en_reg[sec_irq_pkg::OVER_VOLT_EN_BIT],
                    en_reg[sec_irq_pkg::SLEEP_EN_BIT],
                    en_reg[sec_irq_pkg::POL_EN_BIT],
                    en_reg[sec_irq_pkg::JABBER_EN_BIT]};

  // One gate per source, fed by next flag values so that the request
  // rises with the flag and falls in the cycle after the clearing read
  for (genvar i = 0; i < 5; i++) begin : gen_pend
    assign pend_next[i] = flag_next[i] & flag_en[i];
  end

  // Half-full source of the primary register, timed like the others
  assign half_pend_next = half_next & pri_en_reg;

  // Any pending pair raises the request
  assign irq_next = (|pend_next) | half_pend_next;

  // Registered request line, low through and after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_next;
    end
  end

endmodule : phy_secondary_irq_and_rx_error_counter

/* File: testbench/sec_irq_monitor.sv */
`timescale 1ns/10ps
module sec_irq_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic under_volt_i,
  input wire logic over_volt_i,
  input wire logic pol_swap_i,
  input wire logic jabber_i,
  input wire logic carrier_valid_i,
  input wire logic rx_dv_i,
  input wire logic rx_symbol_err_i,
  input wire logic mac_loopback_i
);
  // ----------------------------------------
  // Request decode and quiet conditions
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic map;
  logic rd_sec;
  logic rd_cnt;
  logic quiet;
  logic cq;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign map = wb_adr_i[1:0] == 2'h0 && (wb_adr_i[9:2] inside {8'h12, 8'h13, 8'h15});
  assign rd_sec = take && !wb_we_i && wb_adr_i == 10'h04C;
  assign rd_cnt = take && !wb_we_i && wb_adr_i == 10'h054;
  assign quiet = !under_volt_i && !over_volt_i && !pol_swap_i && !jabber_i;
  assign cq = !(carrier_valid_i && rx_dv_i && rx_symbol_err_i) || mac_loopback_i;
  // Bus answers, read data shape and flag behaviour
  AST_ACK: assert property (take && map |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acked");
  AST_ERR: assert property (take && !map |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_RSVD: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 10'h04C |-> wb_dat_o[13:11] == 3'h0)
    else $error("reserved status bits set");
  AST_UPPER: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_UV: assert property (under_volt_i ##3 rd_sec |=> wb_dat_o[15])
    else $error("undervoltage flag missing");
  AST_JAB: assert property (jabber_i ##3 rd_sec |=> wb_dat_o[8])
    else $error("jabber flag missing");
  AST_CLR: assert property (rd_sec && quiet ##1 quiet [*2] ##1 rd_sec && quiet |=> wb_dat_o[15:14] == 2'h0 && wb_dat_o[9:8] == 2'h0)
    else $error("status not cleared by read");
  AST_CNT: assert property (rd_cnt && cq ##1 cq [*2] ##1 rd_cnt && cq |=> wb_dat_o[15:0] == 16'h0000)
    else $error("counter not cleared by read");
  COV_CNT: cover property (rd_cnt);
  COV_ERR: cover property (take && !map);
  COV_UV: cover property (under_volt_i ##3 rd_sec);
endmodule : sec_irq_monitor

bind phy_secondary_irq_and_rx_error_counter sec_irq_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .under_volt_i(under_volt_i), .over_volt_i(over_volt_i),
  .pol_swap_i(pol_swap_i), .jabber_i(jabber_i), .carrier_valid_i(carrier_valid_i), .rx_dv_i(rx_dv_i),
  .rx_symbol_err_i(rx_symbol_err_i), .mac_loopback_i(mac_loopback_i));

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic clk_i, rst_i, cyc, stb, we, ack, err, irq;
  logic uv, ov, slp, slv, pol, jab, cv, dv, se, lb;
  logic [3:0] sel, r4;
  logic [9:0] adr;
  logic [31:0] wdat, rdat;
  logic [15:0] en;
  int err_count, n_checks, seed, ecnt, k;
  int bits[5] = '{15, 14, 10, 9, 8};
  phy_secondary_irq_and_rx_error_counter dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .under_volt_i(uv), .over_volt_i(ov), .sleep_state_i(slp), .link_slave_i(slv),
    .pol_swap_i(pol), .jabber_i(jab), .carrier_valid_i(cv), .rx_dv_i(dv), .rx_symbol_err_i(se),
    .mac_loopback_i(lb), .irq_o(irq));
  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; unmapped places must be refused
  task automatic bus(input logic w, input logic [9:0] a, input logic [15:0] d, input logic [15:0] x);
    int i;
    logic bad;
    bad = !(a inside {10'h048, 10'h04C, 10'h054});
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'hFFFF, d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if ((ack | err) === 1'b1) break;
    end
    if (i == 20) begin
      chk(16'h0, 16'h1);
      end_sim();
    end
    chk({15'h0, err}, {15'h0, bad});
    if (!w && !bad) begin
      chk(rdat[15:0], x);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  // One-cycle event pulse; sleep is a level that toggles
  task automatic ev(input int n);
    case (n)
      0: uv <= 1'b1;
      1: ov <= 1'b1;
      2: slp <= ~slp;
      3: pol <= 1'b1;
      default: jab <= 1'b1;
    endcase
    @(posedge clk_i);
    {uv, ov, pol, jab} <= 4'h0;
  endtask : ev
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {cyc, stb, we, uv, ov, slp, slv, pol, jab, cv, dv, se, lb} = '0;
    adr = '0;
    wdat = '0;
    sel = 4'hF;
    rst_i = 1'b1;
    seed = 97;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 10'h048, 16'h0, 16'h0000);
    bus(1'b0, 10'h04C, 16'h0, 16'h0000);
    bus(1'b0, 10'h054, 16'h0, 16'h0000);
    bus(1'b0, 10'h050, 16'h0, 16'h0000);
    bus(1'b0, 10'h04E, 16'h0, 16'h0000);
    en = {8'h00, 8'($random(seed))};
    bus(1'b1, 10'h04C, {8'hFF, en[7:0]}, 16'h0);
    bus(1'b0, 10'h04C, 16'h0, en);
    slv <= 1'b1;
    for (k = 0; k < 5; k++) begin
      ev(k);
      repeat (2) @(posedge clk_i);
      chk({15'h0, irq}, {15'h0, en[bits[k] - 8]});
      bus(1'b0, 10'h04C, 16'h0, en | (16'h1 << bits[k]));
      bus(1'b0, 10'h04C, 16'h0, en);
      chk({15'h0, irq}, 16'h0);
    end
    slv <= 1'b0;
    ev(3);
    bus(1'b0, 10'h04C, 16'h0, en);
    ecnt = 0;
    for (k = 0; k < 300; k++) begin
      r4 = 4'($random(seed));
      {cv, dv, se, lb} <= r4;
      @(posedge clk_i);
      if (r4 == 4'hE) ecnt++;
    end
    {cv, dv, se, lb} <= 4'h0;
    bus(1'b0, 10'h054, 16'h0, 16'(ecnt));
    bus(1'b0, 10'h054, 16'h0, 16'h0000);
    bus(1'b1, 10'h048, 16'h0001, 16'h0);
    {cv, dv, se} <= 3'h7;
    repeat (65540) @(posedge clk_i);
    {cv, dv, se} <= 3'h0;
    @(posedge clk_i);
    chk({15'h0, irq}, 16'h1);
    bus(1'b0, 10'h048, 16'h0, 16'h0101);
    bus(1'b0, 10'h054, 16'h0, 16'hFFFF);
    chk({15'h0, irq}, 16'h0);
    end_sim();
  end
endmodule : testbench
